/* rtl/sfiu_pkg.sv */
// package: constants and types for the status flag instruction unit
// Functional notes
// - bit store copies chosen register bit into transfer flag, two clocks (read then execute), others unchanged
// - bit load writes transfer flag into chosen register bit, two clocks (read then execute), flags kept
// - set-sign forces signed-test flag to one in one clock, nothing else
// - clear-sign forces signed-test flag to zero in one clock, nothing else
// - set-overflow sets overflow flag in one clock, only that flag
// - clear-overflow clears overflow flag in one clock, only that flag
// - set-half-carry sets half-carry flag in one clock, only that flag
// - clear-half-carry clears half-carry flag in one clock, only that flag
// - sleep takes one clock, keeps flags, pulses sleep request
// - watchdog restart takes one clock, keeps flags, pulses restart
// - break acts only when debug enabled, keeps flags
package sfiu_pkg;
    // status flag bit positions
    localparam int unsigned FLAG_CARRY     = 0;
    localparam int unsigned FLAG_ZERO      = 1;
    localparam int unsigned FLAG_NEGATIVE  = 2;
    localparam int unsigned FLAG_OVERFLOW  = 3;
    localparam int unsigned FLAG_SIGNED    = 4;
    localparam int unsigned FLAG_HALFCARRY = 5;
    localparam int unsigned FLAG_TRANSFER  = 6;
    localparam int unsigned FLAG_INTERRUPT = 7;
    localparam logic [7:0]  FLAGS_RESET    = 8'h00;
    localparam int unsigned REG_COUNT      = 32;
    // instruction words handled here
    localparam logic [15:0] OP_FLAG_SET_BASE   = 16'h9408; // flag index in bits 6:4
    localparam logic [15:0] OP_FLAG_CLEAR_BASE = 16'h9488;
    localparam logic [15:0] OP_FLAG_MASK       = 16'hff8f;
    localparam logic [15:0] OP_BIT_STORE       = 16'hfa00; // reg 8:4, bit 2:0
    localparam logic [15:0] OP_BIT_LOAD        = 16'hf800;
    localparam logic [15:0] OP_BIT_MASK        = 16'hfe08;
    localparam logic [15:0] OP_NO_OPERATION    = 16'h0000;
    localparam logic [15:0] OP_SLEEP           = 16'h9588;
    localparam logic [15:0] OP_WATCHDOG        = 16'h95a8;
    localparam logic [15:0] OP_BREAK           = 16'h9598;
    typedef enum logic [1:0] {
        SFIU_RUN,
        SFIU_HALT
    } sfiu_state_e;
endpackage

/* rtl/sfiu_regfile.sv */
// general register file: 32 bytes, one read port with registered data, one write port
`timescale 1ns/10ps
module sfiu_regfile (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic [4:0] i_raddr,
    output logic      [7:0] o_rdata,
    input  wire logic       i_we,
    input  wire logic [4:0] i_waddr,
    input  wire logic [7:0] i_wdata
);
    logic [7:0] mem_r [sfiu_pkg::REG_COUNT];

    // storage has no reset; software initialises registers
    always_ff @(posedge i_clk) begin
        if (i_ce && i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end

    // registered read, write-through so a pending write is seen
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= (i_we && i_waddr == i_raddr) ? i_wdata : mem_r[i_raddr];
        end
    end
endmodule

/* rtl/sfiu_top.sv */
// status flag instruction unit: flag, bit transfer and control instructions
`timescale 1ns/10ps
module sfiu_top (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_CE,
    input  wire logic        I_INSTR_VALID,
    input  wire logic [15:0] I_INSTR,
    input  wire logic        I_DEBUG_EN,
    input  wire logic        I_REG_RD_VALID,
    input  wire logic [4:0]  I_REG_RD_ADDR,
    input  wire logic        I_REG_WR_EN,
    input  wire logic [4:0]  I_REG_WR_ADDR,
    input  wire logic [7:0]  I_REG_WR_DATA,
    output logic      [7:0]  O_STATUS_FLAGS,
    output logic      [7:0]  O_REG_RD_DATA,
    output logic             O_DONE,
    output logic             O_SLEEP_REQ,
    output logic             O_WATCHDOG_RESTART,
    output logic             O_BREAK_REQ,
    output logic             O_ILLEGAL
);
    logic [7:0]  status_flags_register_r;
    logic [7:0]  flags_nxt;
    logic        done_r;
    logic        sleep_r;
    logic        wdr_r;
    logic        brk_r;
    logic        ill_r;
    logic        hold_r;
    logic [15:0] held_instr_r;
    sfiu_pkg::sfiu_state_e state_r;
    logic [7:0]  rf_rdata;

    // decode helpers, each used by several paths
    function automatic logic is_flag_op(input logic [15:0] w, input logic [15:0] base);
        is_flag_op = (w & sfiu_pkg::OP_FLAG_MASK) == base;
    endfunction
    function automatic logic is_bit_op(input logic [15:0] w, input logic [15:0] base);
        is_bit_op = (w & sfiu_pkg::OP_BIT_MASK) == base;
    endfunction

    // bit transfers need the source byte, so they take a read cycle first;
    // the flag update itself still lands in the single execution clock
    wire logic        take          = I_INSTR_VALID && state_r == sfiu_pkg::SFIU_RUN;
    wire logic [15:0] cur           = hold_r ? held_instr_r : I_INSTR;
    wire logic        op_flag_set   = is_flag_op(cur, sfiu_pkg::OP_FLAG_SET_BASE);
    wire logic        op_flag_clr   = is_flag_op(cur, sfiu_pkg::OP_FLAG_CLEAR_BASE);
    wire logic        op_bst        = is_bit_op(cur, sfiu_pkg::OP_BIT_STORE);
    wire logic        op_bld        = is_bit_op(cur, sfiu_pkg::OP_BIT_LOAD);
    wire logic        op_nop        = cur == sfiu_pkg::OP_NO_OPERATION;
    wire logic        op_sleep      = cur == sfiu_pkg::OP_SLEEP;
    wire logic        op_wdr        = cur == sfiu_pkg::OP_WATCHDOG;
    wire logic        op_brk        = cur == sfiu_pkg::OP_BREAK;
    wire logic        op_bit        = op_bst || op_bld;
    wire logic [2:0]  flag_idx      = cur[6:4];
    wire logic [2:0]  bit_idx       = cur[2:0];
    wire logic [4:0]  bit_reg       = cur[8:4];
    wire logic        start_bit     = take && !hold_r && op_bit;
    wire logic        exec          = (take && !hold_r && !op_bit) || hold_r;
    wire logic        bst_bit       = rf_rdata[bit_idx];
    wire logic [7:0]  bld_byte      = (rf_rdata & ~(8'h01 << bit_idx))
                                      | ({7'h00, status_flags_register_r[sfiu_pkg::FLAG_TRANSFER]} << bit_idx);
    wire logic        bld_wr        = hold_r && op_bld;
    wire logic        known         = op_flag_set || op_flag_clr || op_bit || op_nop
                                      || op_sleep || op_wdr || op_brk;
    wire logic [4:0]  rf_raddr      = start_bit ? bit_reg : I_REG_RD_ADDR;
    wire logic        rf_we         = bld_wr || (I_REG_WR_EN && !bld_wr);
    wire logic [4:0]  rf_waddr      = bld_wr ? bit_reg : I_REG_WR_ADDR;
    wire logic [7:0]  rf_wdata      = bld_wr ? bld_byte : I_REG_WR_DATA;

    // flag next value: only the addressed flag bit, or the transfer flag on bit store, may move
    always_comb begin
        flags_nxt = status_flags_register_r;
        if (exec && op_flag_set) begin
            flags_nxt[flag_idx] = 1'b1;
        end else if (exec && op_flag_clr) begin
            flags_nxt[flag_idx] = 1'b0;
        end else if (hold_r && op_bst) begin
            flags_nxt[sfiu_pkg::FLAG_TRANSFER] = bst_bit;
        end
        // no-operation, sleep, restart, break and bit load leave flags alone
    end

    // status register and sequencing
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            status_flags_register_r <= sfiu_pkg::FLAGS_RESET;
            hold_r                  <= 1'b0;
            held_instr_r            <= 16'h0000;
            state_r                 <= sfiu_pkg::SFIU_RUN;
        end else if (I_CE) begin
            status_flags_register_r <= flags_nxt;
            hold_r                  <= start_bit;
            if (start_bit) begin
                held_instr_r <= I_INSTR;
            end
            // the sleep controller wakes the core by reset; halt blocks further issue
            state_r <= (exec && op_sleep) ? sfiu_pkg::SFIU_HALT : state_r;
        end
    end

    // single-cycle strobes to the neighbours
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            done_r  <= 1'b0;
            sleep_r <= 1'b0;
            wdr_r   <= 1'b0;
            brk_r   <= 1'b0;
            ill_r   <= 1'b0;
        end else if (I_CE) begin
            done_r  <= exec && known;
            sleep_r <= exec && op_sleep;
            wdr_r   <= exec && op_wdr;
            brk_r   <= exec && op_brk && I_DEBUG_EN;
            ill_r   <= exec && !known;
        end
    end

    // host reads share the port; a bit transfer read takes priority
    logic rd_unused;
    assign rd_unused = I_REG_RD_VALID;

    sfiu_regfile u_regfile (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .i_ce    (I_CE),
        .i_raddr (rf_raddr),
        .o_rdata (rf_rdata),
        .i_we    (rf_we),
        .i_waddr (rf_waddr),
        .i_wdata (rf_wdata)
    );

    assign O_STATUS_FLAGS     = status_flags_register_r;
    assign O_REG_RD_DATA      = rf_rdata;
    assign O_DONE             = done_r;
    assign O_SLEEP_REQ        = sleep_r;
    assign O_WATCHDOG_RESTART = wdr_r;
    assign O_BREAK_REQ        = brk_r;
    assign O_ILLEGAL          = ill_r;
endmodule

/* tb/sfiu_assertions.sv */
// checker: flag update, strobe and halt assertions on the unit's ports
`timescale 1ns/10ps
module sfiu_assertions (
    input wire logic        I_REF_CLK,
    input wire logic        I_RST_N,
    input wire logic        I_CE,
    input wire logic        I_INSTR_VALID,
    input wire logic [15:0] I_INSTR,
    input wire logic        I_DEBUG_EN,
    input wire logic [7:0]  O_STATUS_FLAGS,
    input wire logic        O_DONE,
    input wire logic        O_SLEEP_REQ,
    input wire logic        O_WATCHDOG_RESTART,
    input wire logic        O_BREAK_REQ
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    logic prev_v_r;
    logic halt_r;
    wire  go = I_CE && I_INSTR_VALID && !prev_v_r && !halt_r;
    wire  fset = go && ((I_INSTR & sfiu_pkg::OP_FLAG_MASK) == sfiu_pkg::OP_FLAG_SET_BASE);
    wire  fclr = go && ((I_INSTR & sfiu_pkg::OP_FLAG_MASK) == sfiu_pkg::OP_FLAG_CLEAR_BASE);
    // only words after an idle cycle are judged, a bit op may swallow the next one
    always_ff @(posedge I_REF_CLK) begin
        prev_v_r <= I_RST_N && I_INSTR_VALID;
        halt_r   <= I_RST_N && (halt_r || (go && I_INSTR == sfiu_pkg::OP_SLEEP));
    end
    sequence issued(logic [15:0] w);
        go && I_INSTR == w;
    endsequence
    set_flag_a: assert property (fset |=> O_STATUS_FLAGS == ($past(O_STATUS_FLAGS) | (8'h01 << $past(I_INSTR[6:4]))))
        else $error("flag set wrong");
    clear_flag_a: assert property (fclr |=> O_STATUS_FLAGS == ($past(O_STATUS_FLAGS) & ~(8'h01 << $past(I_INSTR[6:4]))))
        else $error("flag clear wrong");
    flag_done_a: assert property (fset || fclr |-> ##[1:2] O_DONE)
        else $error("no done after flag op");
    idle_hold_a: assert property (!I_INSTR_VALID [*2] |=> $stable(O_STATUS_FLAGS))
        else $error("flags moved while idle");
    halt_hold_a: assert property (halt_r |=> $stable(O_STATUS_FLAGS))
        else $error("flags moved while halted");
    sleep_pulse_a: assert property (issued(sfiu_pkg::OP_SLEEP) |-> ##[1:2] O_SLEEP_REQ ##1 !O_SLEEP_REQ)
        else $error("sleep request not one pulse");
    wdog_pulse_a: assert property (issued(sfiu_pkg::OP_WATCHDOG) |-> ##[1:2] O_WATCHDOG_RESTART ##1 !O_WATCHDOG_RESTART)
        else $error("restart not one pulse");
    break_on_a: assert property (issued(sfiu_pkg::OP_BREAK) and I_DEBUG_EN |-> ##[1:2] O_BREAK_REQ)
        else $error("break missing with debug");
endmodule
bind sfiu_top sfiu_assertions sfiu_assertions_inst (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE),
    .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR(I_INSTR), .I_DEBUG_EN(I_DEBUG_EN), .O_STATUS_FLAGS(O_STATUS_FLAGS),
    .O_DONE(O_DONE), .O_SLEEP_REQ(O_SLEEP_REQ), .O_WATCHDOG_RESTART(O_WATCHDOG_RESTART), .O_BREAK_REQ(O_BREAK_REQ));

/* tb/status_flag_instruction_unit_test.sv */
// testbench: drives instruction words, judges flags, register bits and strobes
`timescale 1ns/10ps
module status_flag_instruction_unit_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        vld = 1'b0;
    logic [15:0] ins = 16'h0000;
    logic        dbg = 1'b0;
    logic        ce = 1'b1;
    logic        ill;
    logic        wen = 1'b0;
    logic [4:0]  wad = 5'h00;
    logic [7:0]  wdt = 8'h00;
    logic [7:0]  flags, rdata, exp_f, exp_r;
    logic        done, slp, watchdog_restart, brk;
    logic [4:0]  seen;
    int          err_total = 0;
    int          check_count = 0;
    sfiu_top sfiu_top_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_INSTR_VALID(vld), .I_INSTR(ins),
        .I_DEBUG_EN(dbg), .I_REG_RD_VALID(1'b1), .I_REG_RD_ADDR(5'h07), .I_REG_WR_EN(wen), .I_REG_WR_ADDR(wad),
        .I_REG_WR_DATA(wdt), .O_STATUS_FLAGS(flags), .O_REG_RD_DATA(rdata), .O_DONE(done), .O_SLEEP_REQ(slp),
        .O_WATCHDOG_RESTART(watchdog_restart), .O_BREAK_REQ(brk), .O_ILLEGAL(ill));
    initial forever #25 clk = ~clk;
    // inputs move 2 ns after the edge so no race with the design's sampling
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one word for one cycle, then strobes gathered over four cycles
    task automatic issue(input logic [15:0] w);
        vld = 1'b1;
        ins = w;
        step();
        vld = 1'b0;
        seen = 5'h00;
        repeat (4) begin
            seen = seen | {ill, done, slp, watchdog_restart, brk};
            step();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wen = 1'b1;
        wad = a;
        wdt = d;
        step();
        wen = 1'b0;
        // one idle edge so a second write never re-raises the enable at once
        step();
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) step();
        rst_n = 1'b1;
        exp_f = 8'h00;
        chk(flags, exp_f, "reset flags");
        chk({4'h0, done, slp, watchdog_restart, brk}, 8'h00, "reset strobes");
    endtask
    // set every flag, then clear each in turn from flag 0 while the later ones stay set
    task automatic t_flags();
        for (int k = 0; k < 16; k++) begin
            issue((k < 8 ? sfiu_pkg::OP_FLAG_SET_BASE : sfiu_pkg::OP_FLAG_CLEAR_BASE) | 16'((k % 8) << 4));
            exp_f[k % 8] = (k < 8);
            chk(flags, exp_f, "flag op");
            chk({7'h0, seen[3]}, 8'h01, "flag done");
        end
        $display("flag test finished");
    endtask
    // with the enable low nothing may move, a word presented then is lost
    task automatic t_freeze();
        ce = 1'b0;
        issue(sfiu_pkg::OP_FLAG_SET_BASE | 16'h0010);
        ce = 1'b1;
        chk(flags, exp_f, "frozen flags");
        chk({3'h0, seen}, 8'h00, "frozen strobes");
        $display("freeze test finished");
    endtask
    // every bit of register 5 into the transfer flag, then flag back into register 7
    task automatic t_bits();
        logic [7:0] src;
        src = 8'h5a;
        wr(5'h05, src);
        wr(5'h07, 8'h81);
        exp_r = 8'h81;
        for (int b = 0; b < 8; b++) begin
            issue(sfiu_pkg::OP_BIT_STORE | 16'h0050 | 16'(b));
            exp_f[6] = src[b];
            chk(flags, exp_f, "bit store");
        end
        // transfer flag one for bit 3, zero for bit 0, so both values land
        for (int b = 3; b >= 0; b -= 3) begin
            issue((b == 3 ? sfiu_pkg::OP_FLAG_SET_BASE : sfiu_pkg::OP_FLAG_CLEAR_BASE) | 16'h0060);
            exp_f[6] = (b == 3);
            chk(flags, exp_f, "transfer flag op");
            issue(sfiu_pkg::OP_BIT_LOAD | 16'h0070 | 16'(b));
            exp_r[b] = exp_f[6];
            chk(rdata, exp_r, "bit load reg");
            chk(flags, exp_f, "bit load flags");
        end
        $display("bit test finished");
    endtask
    // control words; the last clear comes after sleep and must be ignored
    task automatic t_control();
        logic [15:0] cw [7];
        logic [7:0]  cs [7];
        cw = '{sfiu_pkg::OP_NO_OPERATION, sfiu_pkg::OP_WATCHDOG, sfiu_pkg::OP_BREAK, sfiu_pkg::OP_BREAK,
               16'hffff, sfiu_pkg::OP_SLEEP, sfiu_pkg::OP_FLAG_CLEAR_BASE};
        cs = '{8'h08, 8'h0a, 8'h08, 8'h09, 8'h10, 8'h0c, 8'h00};
        issue(sfiu_pkg::OP_FLAG_SET_BASE);
        exp_f[0] = 1'b1;
        for (int i = 0; i < 7; i++) begin
            dbg = (i == 3);
            issue(cw[i]);
            chk({3'h0, seen}, cs[i], "control strobes");
            chk(flags, exp_f, "control flags");
        end
        $display("control test finished");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        do_reset();
        t_flags();
        t_freeze();
        t_bits();
        t_control();
        do_reset();
        close_out();
    end
endmodule
